// ---- core/gibs_pkg.sv ----
package gibs_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] GIBS_ADDR_GENERAL_INPUT_LEVELS = 16'h020c;
  localparam logic [15:0] GIBS_ADDR_RSVD_A               = 16'h020d;
  localparam logic [15:0] GIBS_ADDR_RSVD_B               = 16'h020e;
  localparam logic [15:0] GIBS_ADDR_RSVD_C               = 16'h020f;
  localparam logic [15:0] GIBS_ADDR_BOOT_ERROR_FLAGS     = 16'h0210;
  localparam logic [15:0] GIBS_ADDR_BOOT_DONE_FLAG       = 16'h0211;
  localparam logic [15:0] GIBS_ADDR_RSVD_D               = 16'h0212;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int GIBS_BIT_BOOT_READ_FAILED   = 0;
  localparam int GIBS_BIT_BOOT_CRC_MISMATCH  = 1;
  localparam int GIBS_BIT_BOOT_READ_COMPLETE = 0;
  localparam int GIBS_BIT_INT_SUMMARY        = 0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] GIBS_RESET_BYTE = 8'h00;
  localparam logic       GIBS_RESET_FLAG = 1'b0;
endpackage : gibs_pkg

// ---- core/gibs_status_bank.sv ----
// Summary of operation
// R1 - General-input register low four bits show live levels of input-configured pins.
// R2 - Host writes zeros to reserved bits and ignores their read value.
// R3 - Summary reads 0 and interrupt pin released when no enabled status set.
// R4 - Summary reads 1 and interrupt pin driven low while enabled status set.
// R5 - CRC-mismatch flag sets on boot checksum error; only reset clears it.
// R6 - Boot-failure flag sets on EEPROM read failure; only reset clears it.
// R7 - Boot-complete flag sets when EEPROM read finishes; held until reset.
// R8 - Alarm status bits latch on alarm, cleared by host writing one; here a one on the alarm_clear input clears them, not a register write.
// R9 - Reset clears all three boot flags before a new boot read begins.
module gibs_status_bank
  import gibs_pkg::*;
#(
  parameter int ALARM_W = 4,
  parameter int GPI_W   = 4
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic [GPI_W-1:0]   general_input_level,
  input  wire logic [GPI_W-1:0]   gpio_is_input,
  input  wire logic [ALARM_W-1:0] alarm_event,
  input  wire logic [ALARM_W-1:0] alarm_enable,
  input  wire logic               boot_crc_error,
  input  wire logic               boot_read_error,
  input  wire logic               boot_read_done,
  input  wire logic               reg_rd,
  input  wire logic               reg_wr,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic [7:0]         alarm_clear,
  output logic [7:0]              reg_rdata,
  output logic [ALARM_W-1:0]      lock_lost_sticky,
  output logic                    interrupt_request_n,
  output logic                    interrupt_request_n_oe
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [GPI_W-1:0] gpi_meta_q;
  logic [GPI_W-1:0] gpi_sync_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gpi_meta_q <= '0;
      gpi_sync_q <= '0;
    end else if (clk_en) begin
      gpi_meta_q <= general_input_level;
      gpi_sync_q <= gpi_meta_q;
    end
  end

  // ****************************************
  // Alarm sticky bits
  // ****************************************
  // R8 latch and clear; set wins so no alarm is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_lost_sticky <= '0;
    end else if (clk_en) begin
      lock_lost_sticky <= (lock_lost_sticky & ~alarm_clear[ALARM_W-1:0]) | alarm_event;
    end
  end

  // ****************************************
  // Boot flags
  // ****************************************
  logic crc_q;
  logic fail_q;
  logic done_q;
  // No clear path but reset, so a slow host poll can never miss a boot fault
  // R5 R9 crc mismatch sticky
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crc_q <= GIBS_RESET_FLAG;
    end else if (clk_en && boot_crc_error) begin
      crc_q <= 1'b1;
    end
  end

  // R6 R9 read failure sticky
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fail_q <= GIBS_RESET_FLAG;
    end else if (clk_en && boot_read_error) begin
      fail_q <= 1'b1;
    end
  end

  // R7 R9 boot complete sticky
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q <= GIBS_RESET_FLAG;
    end else if (clk_en && boot_read_done) begin
      done_q <= 1'b1;
    end
  end

  // ****************************************
  // Interrupt summary
  // ****************************************
  logic int_q;
  // R3 R4 summary drives pin; oe low means driving low
  // Open-drain style: the level stays low, only the enable moves
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_q                  <= GIBS_RESET_FLAG;
      interrupt_request_n    <= 1'b0;
      interrupt_request_n_oe <= 1'b1;
    end else if (clk_en) begin
      int_q                  <= |(lock_lost_sticky & alarm_enable);
      interrupt_request_n    <= 1'b0;
      interrupt_request_n_oe <= ~|(lock_lost_sticky & alarm_enable);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Reserved bits read zero, except bit 0 at GIBS_ADDR_RSVD_A which shows the interrupt summary; writes to them are dropped
  logic [7:0] rd_d;
  always_comb begin
    rd_d = GIBS_RESET_BYTE;
    unique case (reg_addr)
      // R1 live input levels
      GIBS_ADDR_GENERAL_INPUT_LEVELS: rd_d[GPI_W-1:0] = gpi_sync_q & gpio_is_input;
      GIBS_ADDR_RSVD_A: rd_d[GIBS_BIT_INT_SUMMARY] = int_q;
      GIBS_ADDR_BOOT_ERROR_FLAGS: begin
        rd_d[GIBS_BIT_BOOT_READ_FAILED]  = fail_q;
        rd_d[GIBS_BIT_BOOT_CRC_MISMATCH] = crc_q;
      end
      GIBS_ADDR_BOOT_DONE_FLAG: rd_d[GIBS_BIT_BOOT_READ_COMPLETE] = done_q;
      default: rd_d = GIBS_RESET_BYTE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= GIBS_RESET_BYTE;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Antecedents other than a_reset_clear skip the reset edge so a one-edge reset never trips a check

  // ****************************************
  // Boot flag checks
  // ****************************************
  a_crc_sets: assert property (!sys_rst && clk_en && boot_crc_error // R5
    |=> crc_q)
    else $error("crc flag not set");
  a_crc_sticky: assert property (!sys_rst && crc_q // R5
    |=> crc_q)
    else $error("crc flag dropped");
  a_fail_sets: assert property (!sys_rst && clk_en && boot_read_error // R6
    |=> fail_q)
    else $error("fail flag not set");
  a_fail_sticky: assert property (!sys_rst && fail_q // R6
    |=> fail_q)
    else $error("fail flag dropped");
  a_done_sets: assert property (!sys_rst && clk_en && boot_read_done // R7
    |=> done_q)
    else $error("done not set");
  a_done_sticky: assert property (!sys_rst && done_q // R7
    |=> done_q)
    else $error("done flag dropped");
  a_write_ignored: assert property ( // R5
    !sys_rst && reg_wr && !boot_crc_error && !boot_read_error && !boot_read_done
    |=> $stable({crc_q, fail_q, done_q}))
    else $error("write changed a boot flag");
  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) // R9
    sys_rst |=> !done_q && !fail_q && !crc_q)
    else $error("flags not cleared");

  // ****************************************
  // Interrupt checks
  // ****************************************
  a_pin_low: assert property (!sys_rst && clk_en && |(lock_lost_sticky & alarm_enable) // R4
    |=> !interrupt_request_n_oe && !interrupt_request_n && int_q)
    else $error("pin not asserted");
  a_pin_free: assert property (!sys_rst && clk_en && !(|(lock_lost_sticky & alarm_enable)) // R3
    |=> interrupt_request_n_oe && !int_q)
    else $error("pin not released");

  // ****************************************
  // Alarm checks
  // ****************************************
  for (genvar i = 0; i < ALARM_W; i++) begin : g_alarm_chk
    a_alarm_latch: assert property (@(posedge clk) disable iff (sys_rst) // R8
      !sys_rst && clk_en && alarm_event[i] |=> lock_lost_sticky[i])
      else $error("alarm lost");
    a_alarm_clear: assert property (@(posedge clk) disable iff (sys_rst) // R8
      !sys_rst && clk_en && alarm_clear[i] && !alarm_event[i] |=> !lock_lost_sticky[i])
      else $error("alarm not cleared");
  end

  // ****************************************
  // Read port checks
  // ****************************************
  a_gpi_read: assert property (!sys_rst && clk_en && reg_rd && reg_addr == GIBS_ADDR_GENERAL_INPUT_LEVELS // R1
    |=> reg_rdata[7:GPI_W] == '0)
    else $error("gpi upper not zero");
  a_gpi_mask: assert property (!sys_rst && clk_en && reg_rd && reg_addr == GIBS_ADDR_GENERAL_INPUT_LEVELS // R1
    |=> (reg_rdata[GPI_W-1:0] & ~$past(gpio_is_input)) == '0)
    else $error("output pin level shown");
  a_summary_read: assert property (!sys_rst && clk_en && reg_rd && reg_addr == GIBS_ADDR_RSVD_A // R4
    |=> reg_rdata[GIBS_BIT_INT_SUMMARY] == $past(int_q))
    else $error("summary bit wrong");
  a_rdata_hold: assert property (!sys_rst && !(clk_en && reg_rd) // R1
    |=> $stable(reg_rdata))
    else $error("read data moved");

  // ****************************************
  // Scenario covers
  // ****************************************
  c_boot_done: cover property (done_q && !fail_q);
  c_boot_fail: cover property (fail_q && crc_q);
  c_int_cycle: cover property (!interrupt_request_n_oe ##[1:20] interrupt_request_n_oe);
  c_set_wins: cover property (clk_en && alarm_event[2] && alarm_clear[2]);
  c_gpi_read: cover property (reg_rd && reg_addr == GIBS_ADDR_GENERAL_INPUT_LEVELS);
endmodule : gibs_status_bank

// ---- bench/gibs_host.sv ----
module gibs_host
  import gibs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  reg_rdata,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [15:0]      reg_addr,
  output logic [7:0]       reg_wdata
);
  // ****************************************
  // Host reads and writes single bytes
  // ****************************************
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 8'h00;
  end
  // Data is taken one edge after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [15:0] a);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= 8'h00;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
endmodule : gibs_host

// ---- bench/tb_gpi_and_boot_status_bank.sv ----
module tb_gpi_and_boot_status_bank;
  import gibs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Bench
  // ****************************************
  logic        clk, sys_rst, clk_en, boot_crc_error, boot_read_error, boot_read_done;
  logic        reg_rd, reg_wr, interrupt_request_n, interrupt_request_n_oe;
  logic [3:0]  general_input_level, gpio_is_input, alarm_event, alarm_enable, lock_lost_sticky;
  logic [7:0]  reg_wdata, alarm_clear, reg_rdata, d;
  logic [15:0] reg_addr;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  gibs_status_bank uut (.clk, .sys_rst, .clk_en, .general_input_level, .gpio_is_input, .alarm_event,
    .alarm_enable, .boot_crc_error, .boot_read_error, .boot_read_done, .reg_rd, .reg_wr, .reg_addr,
    .reg_wdata, .alarm_clear, .reg_rdata, .lock_lost_sticky, .interrupt_request_n, .interrupt_request_n_oe);
  gibs_host host (.clk, .reg_rdata, .reg_rd, .reg_wr, .reg_addr, .reg_wdata);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    host.rd(a, d);
    check(d, exp);
  endtask : rc
  task automatic t_gpi;
    gpio_is_input <= 4'hf;
    general_input_level <= 4'ha;
    repeat (3) @(posedge clk);
    rc(GIBS_ADDR_GENERAL_INPUT_LEVELS, 8'h0a);
    gpio_is_input <= 4'h3;
    rc(GIBS_ADDR_GENERAL_INPUT_LEVELS, 8'h02);
  endtask : t_gpi
  task automatic t_int;
    alarm_enable <= 4'h2;
    alarm_event <= 4'h1;
    @(posedge clk) alarm_event <= 4'h0;
    rc(GIBS_ADDR_RSVD_A, 8'h00);
    check({7'h00, interrupt_request_n_oe}, 8'h01);
    alarm_event <= 4'h2;
    @(posedge clk) alarm_event <= 4'h0;
    rc(GIBS_ADDR_RSVD_A, 8'h01);
    check({7'h00, interrupt_request_n_oe}, 8'h00);
    check({7'h00, interrupt_request_n}, 8'h00);
    alarm_clear <= 8'h02;
    @(posedge clk) alarm_clear <= 8'h00;
    rc(GIBS_ADDR_RSVD_A, 8'h00);
    check({4'h0, lock_lost_sticky}, 8'h01);
    alarm_event <= 4'h4;
    alarm_clear <= 8'h04;
    @(posedge clk) {alarm_event, alarm_clear} <= 12'h000;
    @(posedge clk);
    check({4'h0, lock_lost_sticky}, 8'h05);
  endtask : t_int
  task automatic t_boot;
    boot_read_error <= 1'b1;
    @(posedge clk) boot_read_error <= 1'b0;
    rc(GIBS_ADDR_BOOT_ERROR_FLAGS, 8'h01);
    boot_crc_error <= 1'b1;
    boot_read_done <= 1'b1;
    @(posedge clk) {boot_crc_error, boot_read_done} <= 2'b00;
    host.wr(GIBS_ADDR_BOOT_ERROR_FLAGS);
    rc(GIBS_ADDR_BOOT_ERROR_FLAGS, 8'h03);
    rc(GIBS_ADDR_BOOT_DONE_FLAG, 8'h01);
    rc(GIBS_ADDR_RSVD_D, 8'h00);
    rc(16'h0300, 8'h00);
    sys_rst <= 1'b1;
    @(posedge clk) sys_rst <= 1'b0;
    rc(GIBS_ADDR_BOOT_ERROR_FLAGS, 8'h00);
    rc(GIBS_ADDR_BOOT_DONE_FLAG, 8'h00);
  endtask : t_boot
  initial begin
    {sys_rst, clk_en, boot_crc_error, boot_read_error, boot_read_done} = 5'b11000;
    {general_input_level, gpio_is_input, alarm_event, alarm_enable} = 16'h0000;
    alarm_clear = 8'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rc(GIBS_ADDR_BOOT_ERROR_FLAGS, 8'h00);
    t_gpi();
    t_int();
    t_boot();
    report_and_stop();
  end
endmodule : tb_gpi_and_boot_status_bank
